// [verilog/epi_pkg.sv]
// Package for the two-channel external pin interrupt unit.
// Assumes a 32-bit APB slave and a single 50 MHz clock.
package epi_pkg;
    // Register byte addresses on the bus.
    localparam logic [11:0] EPI_ADDR_SENSE = 12'h000;
    localparam logic [11:0] EPI_ADDR_ENABLE = 12'h004;
    localparam logic [11:0] EPI_ADDR_FLAGS = 12'h008;
    localparam logic [11:0] EPI_ADDR_GLOBAL = 12'h00c;
    localparam logic [11:0] EPI_ADDR_STATUS = 12'h010;
    localparam logic [11:0] EPI_ADDR_MASK = 12'h014;
    localparam logic [11:0] EPI_ADDR_CTRL = 12'h018;

    // Field positions.
    localparam int EPI_SENSE_A_LSB = 0;
    localparam int EPI_SENSE_B_LSB = 2;
    localparam int EPI_EN_A_BIT = 6;
    localparam int EPI_EN_B_BIT = 7;
    localparam int EPI_GIE_BIT = 0;
    localparam int EPI_CTRL_SLEEP_BIT = 0;
    localparam int EPI_CTRL_WAKE_BIT = 1;
    localparam int EPI_ACK_A_BIT = 0;
    localparam int EPI_ACK_B_BIT = 1;

    // Reset values.
    localparam logic [7:0] EPI_RST_BYTE = 8'h00;
    localparam logic [31:0] EPI_RST_WORD = 32'h0000_0000;

    // Sense encodings.
    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'h0,
        EPI_SENSE_ANY = 2'h1,
        EPI_SENSE_FALL = 2'h2,
        EPI_SENSE_RISE = 2'h3
    } epi_sense_e;

    // Wake timing: slow sampling clock period and the start-up wait.
    localparam int EPI_CLK_MHZ = 50;
    localparam int EPI_WDT_PERIOD_US = 1;
    localparam int EPI_WDT_CYCLES = EPI_WDT_PERIOD_US * EPI_CLK_MHZ;
    localparam int EPI_WAKE_SAMPLES = 2;
    localparam int EPI_STARTUP_CYCLES_DEF = 64;

    // APB request bundle.
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } epi_apb_req_s;
endpackage

// [verilog/epi_chan.sv]
// One pin channel: synchroniser, edge detection and request flag.
// Assumes the pin is asynchronous to the clock and io_run gates the I/O clock.
`timescale 1ns/10ps
module epi_chan
    import epi_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Pin and configuration.
    input wire logic i_pin,
    input wire logic [1:0] i_sense,
    input wire logic i_io_run,
    // Flag clear requests.
    input wire logic i_clr_sw,
    input wire logic i_clr_ack,
    // Results.
    output logic o_flag,
    output logic o_low,
    output logic o_pin_sync
);
    logic sync1;
    logic sync2;
    logic prev;
    logic flag;
    logic next_flag;
    wire sense_e_low = (i_sense == EPI_SENSE_LOW);
    wire rise = sync2 & ~prev;
    wire fall = ~sync2 & prev;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= i_pin;
            sync2 <= sync1;
        end
    end

    // Previous value only moves while the I/O clock runs, so a net pin change in deep sleep shows as one edge once it runs again.
    // stalls in sleep
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev <= 1'b1;
        end else if (i_io_run) begin
            prev <= sync2;
        end
    end

    wire edge_hit = i_io_run & (((i_sense == EPI_SENSE_ANY) & (rise | fall)) |
                                ((i_sense == EPI_SENSE_FALL) & fall) |
                                ((i_sense == EPI_SENSE_RISE) & rise));

    always_comb begin
        next_flag = flag;
        if (i_clr_sw || i_clr_ack) begin
            next_flag = 1'b0;
        end
        if (edge_hit) begin
            next_flag = 1'b1;
        end
        if (sense_e_low) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    assign o_low = sense_e_low & ~sync2;
    assign o_flag = flag;
    assign o_pin_sync = sync2;
endmodule

// [verilog/epi_top.sv]
// Two-channel external pin interrupt unit with an APB register file.
// Assumes pins are plain inputs (pin-as-output loops back on the same wire)
// and the core reports vector entry with one-cycle acknowledge pulses.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module epi_top
    import epi_pkg::*;
#(
    parameter int STARTUP_CYCLES = EPI_STARTUP_CYCLES_DEF
)
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Interrupt pins.
    input wire logic I_EXT_IRQ_PIN_A,
    input wire logic I_EXT_IRQ_PIN_B,
    // Core side: vector entry acknowledges.
    input wire logic I_ACK_A,
    input wire logic I_ACK_B,
    // Core side: per-vector requests, wake and summary interrupt.
    output logic O_REQ_A,
    output logic O_REQ_B,
    output logic O_WAKE,
    output logic O_IRQ
);
    // Elaboration check: a zero start-up count would leave the wake sequence without a start-up phase.
    if (STARTUP_CYCLES < 1) begin : gen_bad_startup
        $error("STARTUP_CYCLES must be at least one");
    end

    localparam int WDT_W = $clog2(EPI_WDT_CYCLES + 1);
    localparam int SU_W = $clog2(STARTUP_CYCLES + 1);

    typedef enum logic [3:0] {
        EPI_RUN = 4'h1,
        EPI_SLEEP = 4'h2,
        EPI_STARTUP = 4'h4,
        EPI_DONE = 4'h8
    } epi_wake_e;

    epi_apb_req_s req;
    logic [7:0] sense_ctl;
    logic [7:0] pin_en;
    logic gie;
    logic sleep_req;
    logic [3:0] status;
    logic [3:0] mask;
    logic [1:0] chan_flag;
    logic [1:0] chan_low;
    logic [1:0] pin_sync;
    epi_wake_e wake_st;
    epi_wake_e next_wake_st;
    logic [WDT_W-1:0] wdt_cnt;
    logic [1:0] wdt_hits;
    logic [SU_W-1:0] su_cnt;
    logic [1:0] prev_req;

    assign req = '{sel: i_psel, enable: i_penable, write: i_pwrite, addr: i_paddr, wdata: i_pwdata};

    // Bus decode: a write lands only at the edge that sees pready high, so a W1C lands once per transfer.
    wire acc = req.sel & req.enable;
    wire wr_ok = acc & o_pready & req.write & i_pstrb[0];
    wire hit_sense = (req.addr == EPI_ADDR_SENSE);
    wire hit_enable = (req.addr == EPI_ADDR_ENABLE);
    wire hit_flags = (req.addr == EPI_ADDR_FLAGS);
    wire hit_global = (req.addr == EPI_ADDR_GLOBAL);
    wire hit_status = (req.addr == EPI_ADDR_STATUS);
    wire hit_mask = (req.addr == EPI_ADDR_MASK);
    wire hit_ctrl = (req.addr == EPI_ADDR_CTRL);
    wire hit_any = hit_sense | hit_enable | hit_flags | hit_global | hit_status | hit_mask | hit_ctrl;
    wire [1:0] flag_w1c = (wr_ok & hit_flags) ? {req.wdata[EPI_EN_B_BIT], req.wdata[EPI_EN_A_BIT]} : 2'h0;
    wire io_run = (wake_st == EPI_RUN);

    // Per-channel sense fields and ack wires, one instance per channel.
    wire [1:0] pins = {I_EXT_IRQ_PIN_B, I_EXT_IRQ_PIN_A};
    wire [1:0] acks = {I_ACK_B, I_ACK_A};
    wire [1:0] sense_a = sense_ctl[EPI_SENSE_A_LSB +: 2];
    wire [1:0] sense_b = sense_ctl[EPI_SENSE_B_LSB +: 2];
    wire [3:0] sense_all = {sense_b, sense_a};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            epi_chan u_chan (
                .i_clk(I_CLK),
                .i_rst_n(I_RST_N),
                .i_pin(pins[g]),
                .i_sense(sense_all[2*g +: 2]),
                .i_io_run(io_run),
                .i_clr_sw(flag_w1c[g]),
                .i_clr_ack(acks[g]),
                .o_flag(chan_flag[g]),
                .o_low(chan_low[g]),
                .o_pin_sync(pin_sync[g])
            );
        end
    endgenerate

    wire [1:0] chan_en = {pin_en[EPI_EN_B_BIT], pin_en[EPI_EN_A_BIT]};
    wire [1:0] next_req = {2{gie}} & chan_en & (chan_flag | chan_low) & {2{io_run}};
    wire any_low = |({2{gie}} & chan_en & chan_low);

    // Register writes; sleep entry is a software request cleared on wake.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sense_ctl <= EPI_RST_BYTE;
            pin_en <= EPI_RST_BYTE;
            gie <= 1'b0;
            mask <= 4'h0;
        end else if (wr_ok) begin
            if (hit_sense) sense_ctl <= req.wdata[7:0];
            if (hit_enable) pin_en <= req.wdata[7:0] & 8'hc0;
            if (hit_global) gie <= req.wdata[EPI_GIE_BIT];
            if (hit_mask) mask <= req.wdata[3:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sleep_req <= 1'b0;
        end else if (wr_ok && hit_ctrl) begin
            sleep_req <= req.wdata[EPI_CTRL_SLEEP_BIT];
        end else if (wake_st == EPI_DONE) begin
            sleep_req <= 1'b0;
        end
    end

    wire wdt_tick = (wdt_cnt == WDT_W'(EPI_WDT_CYCLES - 1));
    wire su_end = (su_cnt == SU_W'(STARTUP_CYCLES - 1));
    always_comb begin
        next_wake_st = wake_st;
        case (wake_st)
            EPI_RUN: if (sleep_req) next_wake_st = EPI_SLEEP;
            EPI_SLEEP: if (wdt_tick && any_low && wdt_hits == 2'(EPI_WAKE_SAMPLES - 1)) next_wake_st = EPI_STARTUP;
            EPI_STARTUP: if (su_end) next_wake_st = EPI_DONE;
            EPI_DONE: next_wake_st = EPI_RUN;
            default: next_wake_st = EPI_RUN;
        endcase
    end

    // Slow sampling clock and start-up counters; a lost level restarts the count.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wake_st <= EPI_RUN;
            wdt_cnt <= '0;
            wdt_hits <= 2'h0;
            su_cnt <= '0;
        end else begin
            wake_st <= next_wake_st;
            wdt_cnt <= (wdt_tick || wake_st != EPI_SLEEP) ? '0 : wdt_cnt + 1'b1;
            if (wake_st != EPI_SLEEP) wdt_hits <= 2'h0;
            else if (wdt_tick) wdt_hits <= any_low ? wdt_hits + 1'b1 : 2'h0;
            su_cnt <= (wake_st == EPI_STARTUP) ? su_cnt + 1'b1 : '0;
        end
    end

    // Status bits: 0/1 request raised on A/B, 2 wake done, 3 level lost before start-up end.
    // wake without interrupt
    wire [3:0] events = {(wake_st == EPI_DONE) & ~any_low, wake_st == EPI_DONE,
                         next_req[1] & ~prev_req[1], next_req[0] & ~prev_req[0]};
    wire [3:0] st_w1c = (wr_ok & hit_status) ? req.wdata[3:0] : 4'h0;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            status <= 4'h0;
            prev_req <= 2'h0;
        end else begin
            status <= (status & ~st_w1c) | events;
            prev_req <= next_req;
        end
    end

    // Read mux; flags read zero in level mode because the channel holds them clear.
    wire [31:0] rd_mux =
        hit_sense ? {24'h0, sense_ctl} :
        hit_enable ? {24'h0, pin_en} :
        hit_flags ? {24'h0, chan_flag[1], chan_flag[0], 6'h0} :
        hit_global ? {31'h0, gie} :
        hit_status ? {28'h0, status} :
        hit_mask ? {28'h0, mask} :
        hit_ctrl ? {30'h0, io_run, sleep_req} : EPI_RST_WORD;

    // Outputs registered; the answer comes in the access cycle's next edge.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            o_prdata <= EPI_RST_WORD;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            O_REQ_A <= 1'b0;
            O_REQ_B <= 1'b0;
            O_WAKE <= 1'b0;
            O_IRQ <= 1'b0;
        end else begin
            o_pready <= acc & ~o_pready;
            o_pslverr <= acc & ~o_pready & ~hit_any;
            o_prdata <= (acc & ~o_pready & ~req.write) ? rd_mux : EPI_RST_WORD;
            O_REQ_A <= next_req[0];
            O_REQ_B <= next_req[1];
            O_WAKE <= (wake_st == EPI_DONE);
            O_IRQ <= |((status & ~st_w1c | events) & mask);
        end
    end
endmodule

// [tb/epi_pin_src.sv]
// Model of the outside sources that drive the two interrupt pins.
// Assumes the bench commands each level change through the drive task.
`timescale 1ns/10ps
module epi_pin_src (
    // Clock.
    input wire logic i_clk,
    // Pin levels.
    output logic o_pin_a,
    output logic o_pin_b
);
    // Both pins idle high, as a pull-up would leave them.
    initial begin
        o_pin_a = 1'b1;
        o_pin_b = 1'b1;
    end

    // held past one clock
    // A level is held at least two clocks, so that a shorter glitch is never relied upon.
    task automatic drive(input bit ch, input logic lvl, input int hold);
        @(posedge i_clk);
        if (ch) begin
            o_pin_b <= lvl;
        end else begin
            o_pin_a <= lvl;
        end
        repeat ((hold < 2) ? 2 : hold) @(posedge i_clk);
    endtask
endmodule

// [tb/epi_top_checker.sv]
// Concurrent checks on the ports of the pin interrupt unit.
// Assumes it is bound to epi_top and sees only that module's ports.
`timescale 1ns/10ps
module epi_top_checker
    import epi_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Pin and core side.
    input wire logic I_EXT_IRQ_PIN_A,
    input wire logic O_REQ_A,
    input wire logic O_REQ_B,
    input wire logic O_WAKE
);
    logic en_a, en_b, gie, slept;
    logic [1:0] sa;
    // A write lands at the edge that sees pready high, so the enable, gie and sense copies follow the registers exactly; slept never clears.
    wire wr_take = i_psel && i_penable && i_pwrite && i_pstrb[0] && o_pready;
    wire act_a = gie && en_a;
    wire act_b = gie && en_b;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            {en_a, en_b, gie, slept, sa} <= '0;
        end else if (wr_take) begin
            en_a <= (i_paddr == EPI_ADDR_ENABLE) ? i_pwdata[6] : en_a;
            en_b <= (i_paddr == EPI_ADDR_ENABLE) ? i_pwdata[7] : en_b;
            gie <= (i_paddr == EPI_ADDR_GLOBAL) ? i_pwdata[0] : gie;
            sa <= (i_paddr == EPI_ADDR_SENSE) ? i_pwdata[1:0] : sa;
            slept <= slept || (i_paddr == EPI_ADDR_CTRL && i_pwdata[0]);
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    pready_resp_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready missing one cycle into the access phase");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");
    slverr_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    gate_req_a_a: assert property (!act_a && !$past(act_a) |-> !O_REQ_A)
        else $error("request A raised while not enabled");
    gate_req_b_a: assert property (!act_b && !$past(act_b) |-> !O_REQ_B)
        else $error("request B raised while not enabled");
    wake_pulse_a: assert property (O_WAKE |=> !O_WAKE)
        else $error("wake held longer than one cycle");
    fall_req_a: assert property (act_a && sa == EPI_SENSE_FALL && !slept && $fell(I_EXT_IRQ_PIN_A)
        ##1 !I_EXT_IRQ_PIN_A [*3] |-> ##[0:2] O_REQ_A)
        else $error("falling edge on pin A gave no request");
endmodule

bind epi_top epi_top_checker u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .I_EXT_IRQ_PIN_A(I_EXT_IRQ_PIN_A), .O_REQ_A(O_REQ_A), .O_REQ_B(O_REQ_B), .O_WAKE(O_WAKE));

// [tb/epi_top_tb.sv]
// Self-checking bench for the pin interrupt unit.
// Assumes epi_pin_src drives the pins and the checker is bound separately.
`timescale 1ns/10ps
module epi_top_tb;
    import epi_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ack_a = 1'b0;
    logic ack_b = 1'b0;
    logic pin_a, pin_b, req_a, req_b, wake, irq, pready, pslverr;
    logic [31:0] prdata;
    epi_apb_req_s req = '0;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    logic [11:0] regs [6] = '{EPI_ADDR_SENSE, EPI_ADDR_ENABLE, EPI_ADDR_FLAGS, EPI_ADDR_GLOBAL,
        EPI_ADDR_STATUS, EPI_ADDR_MASK};

    // Clock at 50 MHz.
    always #10 clk = ~clk;

    epi_pin_src src (.i_clk(clk), .o_pin_a(pin_a), .o_pin_b(pin_b));
    // A short start-up count keeps the wake run brief.
    epi_top #(.STARTUP_CYCLES(4)) dut (.I_CLK(clk), .I_RST_N(rst_n), .i_psel(req.sel),
        .i_penable(req.enable), .i_pwrite(req.write), .i_paddr(req.addr), .i_pwdata(req.wdata),
        .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .I_EXT_IRQ_PIN_A(pin_a), .I_EXT_IRQ_PIN_B(pin_b), .I_ACK_A(ack_a), .I_ACK_B(ack_b),
        .O_REQ_A(req_a), .O_REQ_B(req_b), .O_WAKE(wake), .O_IRQ(irq));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is seen, then released for a cycle.
    // Only the watchdog ends a wait that never gets its answer.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.enable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk("rdata", exp, q);
        chk("pslverr", 32'(err), 32'(e));
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs a few hundred cycles.
    initial begin
        #(20 * 30000);
        bad_count++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (regs[i]) rd(regs[i], 32'h0);
        rd(12'h020, 32'h0, 1'b1);
        wr(EPI_ADDR_GLOBAL, 32'h1);
        wr(EPI_ADDR_ENABLE, 32'hc0);
        rd(EPI_ADDR_ENABLE, 32'hc0);
        wr(EPI_ADDR_MASK, 32'h1);
        wr(EPI_ADDR_SENSE, 32'h0e);
        src.drive(0, 1'b0, 6);
        chk("req_a", 32'h1, 32'(req_a));
        chk("req_b", 32'h0, 32'(req_b));
        chk("irq", 32'h1, 32'(irq));
        src.drive(1, 1'b0, 6);
        src.drive(1, 1'b1, 6);
        chk("req_b", 32'h1, 32'(req_b));
        rd(EPI_ADDR_FLAGS, 32'hc0);
        wr(EPI_ADDR_FLAGS, 32'h40);
        rd(EPI_ADDR_FLAGS, 32'h80);
        wr(EPI_ADDR_FLAGS, 32'h0);
        rd(EPI_ADDR_FLAGS, 32'h80);
        ack_b <= 1'b1;
        @(posedge clk);
        ack_b <= 1'b0;
        rd(EPI_ADDR_FLAGS, 32'h0);
        chk("req_b", 32'h0, 32'(req_b));
        wr(EPI_ADDR_STATUS, 32'hf);
        chk("irq", 32'h0, 32'(irq));
        // Any change, masked summary interrupt.
        wr(EPI_ADDR_MASK, 32'h0);
        wr(EPI_ADDR_SENSE, 32'h0d);
        src.drive(0, 1'b1, 6);
        rd(EPI_ADDR_FLAGS, 32'h40);
        chk("irq", 32'h0, 32'(irq));
        wr(EPI_ADDR_FLAGS, 32'h40);
        src.drive(0, 1'b0, 6);
        rd(EPI_ADDR_FLAGS, 32'h40);
        wr(EPI_ADDR_FLAGS, 32'h40);
        // Global enable off: the flag sets but no request.
        wr(EPI_ADDR_GLOBAL, 32'h0);
        src.drive(0, 1'b1, 6);
        chk("req_a", 32'h0, 32'(req_a));
        rd(EPI_ADDR_FLAGS, 32'h40);
        wr(EPI_ADDR_GLOBAL, 32'h1);
        // The enable lands with pready, the registered request one edge later.
        @(posedge clk);
        chk("req_a", 32'h1, 32'(req_a));
        wr(EPI_ADDR_FLAGS, 32'h40);
        // Low level: requests while low, flag reads zero.
        wr(EPI_ADDR_SENSE, 32'h0c);
        src.drive(0, 1'b0, 6);
        chk("req_a", 32'h1, 32'(req_a));
        rd(EPI_ADDR_FLAGS, 32'h0);
        src.drive(0, 1'b1, 6);
        chk("req_a", 32'h0, 32'(req_a));
        // Sleep, then wake on a held low level.
        wr(EPI_ADDR_STATUS, 32'hf);
        wr(EPI_ADDR_CTRL, 32'h1);
        src.drive(0, 1'b0, 2);
        n = 0;
        while (wake !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk("wake", 32'h1, 32'(wake));
        repeat (6) @(posedge clk);
        chk("req_a", 32'h1, 32'(req_a));
        rd(EPI_ADDR_STATUS, 32'h5);
        complete_run();
    end
endmodule
